// file: hw/sti_pkg.sv
//------------------------------------------------------------------------------
// Purpose: shared constants and types of the standard and top-level irq unit
// Assumes: one 50 MHz clock, asynchronous active-low reset
// Notes:   cycle figures are counts of clk cycles
//------------------------------------------------------------------------------
//------------------------------------------------------------------------------
package sti_pkg;

    //--------------------------------------------------------------------------
    // channel layout
    //--------------------------------------------------------------------------
    localparam int NUM_STD  = 10;                // E0..I1
    localparam int NUM_CAN  = 8;                 // E0..H1
    localparam int CH_I0    = 8;
    localparam int CH_I1    = 9;                 // reserved, never pending
    localparam int PRIO_W   = 3;
    localparam logic [2:0] PRIO_NEVER = 3'h7;    // lowest, never served
    localparam int VEC_LO   = 1;                 // channel field position in vector
    localparam int VEC_HI_POS = 5;               // upper vector bits position

    //--------------------------------------------------------------------------
    // reset values
    //--------------------------------------------------------------------------
    localparam logic TOP_SRC_RST = 1'b1;         // pin is top source after reset
    localparam logic TOP_NM_RST  = 1'b0;

    //--------------------------------------------------------------------------
    // timing counts in clk cycles
    //--------------------------------------------------------------------------
    localparam logic [2:0] SAMPLE_PERIOD = 3'h5;
    localparam logic [2:0] ARB_CYCLES    = 3'h5;
    localparam logic [4:0] ENTRY_BASE    = 5'h12;  // 18 cycles
    localparam logic [4:0] ENTRY_STACK   = 5'h02;
    localparam logic [4:0] ENTRY_CSR     = 5'h02;
    localparam logic [4:0] ENTRY_WAKE    = 5'h01;
    localparam int RESP_STD_MIN = 26;
    localparam int RESP_STD_MAX = 55;
    localparam int RESP_TOP_MIN = 22;
    localparam int RESP_TOP_MAX = 51;

    //--------------------------------------------------------------------------
    // arbitration states
    //--------------------------------------------------------------------------
    typedef enum logic [4:0] {
        ST_SAMPLE = 5'h01,
        ST_ARB    = 5'h02,
        ST_REQ    = 5'h04,
        ST_ACK    = 5'h08,
        ST_TOPSVC = 5'h10
    } sti_state_t;

    typedef struct packed {
        sti_state_t          st;
        logic [2:0]          sampCnt;
        logic [2:0]          arbCnt;
        logic [NUM_STD-1:0]  pending;
        logic [NUM_STD-1:0]  overrun;
        logic                topPending;
        logic                topSrcSel;
        logic                notMaskable;
        logic                winTop;
        logic [3:0]          winIdx;
        logic [7:0]          vector;
        logic                irqReq;
        logic                topReq;
        logic                abortInstr;
        logic                finishFirst;
        logic                ackPulse;
        logic                ienClear;
        logic [4:0]          entryCycles;
    } sti_regs_t;

endpackage

// file: hw/sti_edge_detect.sv
//------------------------------------------------------------------------------
// Purpose: per-bit selectable edge detector, one-cycle event pulses
// Assumes: inputs synchronous to clk
// Notes:   a level must stand one cycle for its edge to be seen
//------------------------------------------------------------------------------
module sti_edge_detect
    import sti_pkg::*;
#(
    parameter int W = 10
)
(
    input  wire logic         clk,
    input  wire logic         arst_n,
    input  wire logic [W-1:0] src,
    input  wire logic [W-1:0] risingSel,
    output logic      [W-1:0] evt
);

    typedef struct packed {
        logic [W-1:0] prev;
        logic [W-1:0] evt;
    } ste_regs_t;

    ste_regs_t r;
    ste_regs_t next_r;

    // rising or falling edge per bit against last sample
    always_comb
    begin
        next_r      = r;
        next_r.prev = src;
        next_r.evt  = (risingSel & src & ~r.prev) | (~risingSel & ~src & r.prev);
    end

    // state register
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            r <= '0;
        end
        else
        begin
            r <= next_r;
        end
    end

    assign evt = r.evt;

    edge_pulse_a: assert property (@(posedge clk) disable iff (!arst_n)
        $rose(src[0]) && risingSel[0] |=> evt[0])
        else $error("rising edge not reported");

endmodule

// file: hw/sti_irq_unit.sv
//------------------------------------------------------------------------------
// Purpose: standard channels E0..I1 plus top-level interrupt and arbitration
// Assumes: core acknowledges with one-cycle pulses; config bits are plain ports
// Notes:   arbitration sampling runs free, independent of the core
//------------------------------------------------------------------------------
module sti_irq_unit
    import sti_pkg::*;
(
    input  wire logic         clk,
    input  wire logic         arst_n,
    // peripheral sources
    input  wire logic [7:0]   canSrc,
    input  wire logic         serialSrc,
    // standard channel configuration
    input  wire logic [7:0]   stdEdgeSelectLow,
    input  wire logic         chanI0EdgeSelect,
    input  wire logic [7:0]   stdMaskLow,
    input  wire logic         stdMaskHigh,
    input  wire logic [7:0]   stdPriorityLow,
    input  wire logic [1:0]   stdPriorityHigh,
    input  wire logic [2:0]   vectorUpper,
    input  wire logic [9:0]   stdPendSet,
    input  wire logic [9:0]   stdPendClr,
    input  wire logic [9:0]   overrunClr,
    // top-level source and controls
    input  wire logic         nmiPin,
    input  wire logic         wdEndCount,
    input  wire logic         topSrcWr,
    input  wire logic         topSrcData,
    input  wire logic         topEdgeSelect,
    input  wire logic         topMaskableEnable,
    input  wire logic         topPendSet,
    input  wire logic         topNmSet,
    input  wire logic         globalIrqEnable,
    input  wire logic [2:0]   currentPriorityLevel,
    // core side
    input  wire logic         coreAck,
    input  wire logic         coreWriteDone,
    input  wire logic         topReturn,
    input  wire logic         stackInRegFile,
    input  wire logic         codeSegPushEnable,
    input  wire logic         waitForIrq,
    // status and requests
    output logic [7:0]        stdPendingLow,
    output logic [1:0]        stdPendingHigh,
    output logic [9:0]        overrunFlags,
    output logic [7:0]        stdSharedVector,
    output logic              topPending,
    output logic              topSourceSelect,
    output logic              topNotMaskable,
    output logic              irqReq,
    output logic              topReq,
    output logic              abortInstr,
    output logic              finishFirst,
    output logic              ackPulse,
    output logic              ackIsTop,
    output logic              ienClear,
    output logic              dmaBlock,
    output logic [4:0]        entryCycles
);

    //--------------------------------------------------------------------------
    // edge detection
    //--------------------------------------------------------------------------
    logic [NUM_STD-1:0] stdEvt;
    logic [1:0]         topEvt;
    logic [NUM_STD-1:0] stdSrc;
    logic [NUM_STD-1:0] stdRise;

    // CAN pairs in rx0, rx1, tx, status order, serial on I0, I1 tied off
    assign stdSrc  = {1'b0, serialSrc, canSrc};
    assign stdRise = {1'b1, chanI0EdgeSelect, stdEdgeSelectLow};

    sti_edge_detect #(.W(NUM_STD)) stdEdges
    (
        .clk       (clk),
        .arst_n    (arst_n),
        .src       (stdSrc),
        .risingSel (stdRise),
        .evt       (stdEvt)
    );

    // watchdog end of count always on its rising edge
    sti_edge_detect #(.W(2)) topEdges
    (
        .clk       (clk),
        .arst_n    (arst_n),
        .src       ({wdEndCount, nmiPin}),
        .risingSel ({1'b1, topEdgeSelect}),
        .evt       (topEvt)
    );

    //--------------------------------------------------------------------------
    // state and combinational helpers
    //--------------------------------------------------------------------------
    sti_regs_t r;
    sti_regs_t next_r;

    logic [NUM_STD-1:0] maskVec;
    logic [9:0]         prioPairs;
    logic [2:0]         prio [NUM_STD];
    logic [NUM_STD-1:0] eligible;
    logic               stdFound;
    logic [3:0]         winIdxC;
    logic [2:0]         winPrio;
    logic               pendFound;
    logic [3:0]         pendIdx;
    logic [2:0]         pendPrio;
    logic               topEvent;
    logic               topCand;
    logic               sampTick;
    logic [NUM_STD-1:0] ackClr;

    assign maskVec   = {1'b0, stdMaskHigh, stdMaskLow};
    assign prioPairs = {stdPriorityHigh, stdPriorityLow};
    assign sampTick  = (r.sampCnt == SAMPLE_PERIOD - 3'h1);

    // upper two bits per pair, low bit is channel parity
    always_comb
    begin
        for (int i = 0; i < NUM_STD; i++)
        begin
            prio[i] = {prioPairs[2*(i/2)+1], prioPairs[2*(i/2)], i[0]};
        end
    end

    // eligibility: pending, unmasked, enabled, above current level
    always_comb
    begin
        for (int i = 0; i < NUM_STD; i++)
        begin
            eligible[i] = r.pending[i] && maskVec[i] && globalIrqEnable
                          && (prio[i] != PRIO_NEVER)
                          && (prio[i] < currentPriorityLevel);
        end
    end

    // strict compare keeps the lower channel on ties, E0 first
    always_comb
    begin
        stdFound  = 1'b0;
        winIdxC   = 4'h0;
        winPrio   = PRIO_NEVER;
        pendFound = 1'b0;
        pendIdx   = 4'h0;
        pendPrio  = PRIO_NEVER;
        for (int i = 0; i < NUM_STD; i++)
        begin
            if (eligible[i] && (!stdFound || prio[i] < winPrio))
            begin
                stdFound = 1'b1;
                winIdxC  = 4'(i);
                winPrio  = prio[i];
            end
            if (r.pending[i] && (!pendFound || prio[i] < pendPrio))
            begin
                pendFound = 1'b1;
                pendIdx   = 4'(i);
                pendPrio  = prio[i];
            end
        end
    end

    // top-level source and gating
    assign topEvent = r.topSrcSel ? topEvt[0] : topEvt[1];
    assign topCand  = r.topPending
                      && (r.notMaskable
                          || (topMaskableEnable && globalIrqEnable));

    // winner pending cleared in the extra acknowledge cycle
    always_comb
    begin
        ackClr = '0;
        if (r.st == ST_ACK && !r.winTop)
        begin
            ackClr[r.winIdx] = 1'b1;
        end
    end

    //--------------------------------------------------------------------------
    // next state
    //--------------------------------------------------------------------------
    always_comb
    begin
        next_r             = r;
        next_r.abortInstr  = 1'b0;
        next_r.finishFirst = 1'b0;
        next_r.ackPulse    = 1'b0;
        next_r.ienClear    = 1'b0;
        // free-running sample divider
        next_r.sampCnt = sampTick ? 3'h0 : r.sampCnt + 3'h1;
        // hardware set and software set win over any clear
        next_r.pending = ((r.pending & ~stdPendClr & ~ackClr)
                          | stdEvt | stdPendSet) & ~(NUM_STD'(1) << CH_I1);
        next_r.overrun = (r.overrun & ~overrunClr) | (stdEvt & r.pending);
        next_r.vector  = {vectorUpper, pendIdx, 1'b0};
        // top pending, cleared only by its own acknowledge
        if (r.st == ST_ACK && r.winTop)
        begin
            next_r.topPending = 1'b0;
        end
        if (topEvent || topPendSet)
        begin
            next_r.topPending = 1'b1;
        end
        if (topSrcWr)
        begin
            next_r.topSrcSel = topSrcData;
        end
        if (topNmSet)
        begin
            next_r.notMaskable = 1'b1;
        end
        case (r.st)
            ST_SAMPLE:
            begin
                if (sampTick && (topCand || stdFound))
                begin
                    next_r.st     = ST_ARB;
                    next_r.arbCnt = 3'h0;
                    next_r.winTop = topCand;
                    next_r.winIdx = winIdxC;
                end
            end
            ST_ARB:
            begin
                next_r.arbCnt = r.arbCnt + 3'h1;
                if (r.arbCnt == ARB_CYCLES - 3'h1)
                begin
                    next_r.st          = ST_REQ;
                    next_r.irqReq      = !r.winTop;
                    next_r.topReq      = r.winTop;
                    next_r.abortInstr  = !coreWriteDone;
                    next_r.finishFirst = coreWriteDone;
                end
            end
            ST_REQ:
            begin
                if (coreAck)
                begin
                    next_r.st          = ST_ACK;
                    next_r.irqReq      = 1'b0;
                    next_r.topReq      = 1'b0;
                    next_r.ackPulse    = 1'b1;
                    next_r.ienClear    = !r.winTop;
                    next_r.entryCycles = ENTRY_BASE
                        + (stackInRegFile ? ENTRY_STACK : 5'h00)
                        + (codeSegPushEnable ? ENTRY_CSR : 5'h00)
                        + (waitForIrq ? ENTRY_WAKE : 5'h00);
                end
            end
            ST_ACK:
            begin
                next_r.st = r.winTop ? ST_TOPSVC : ST_SAMPLE;
            end
            ST_TOPSVC:
            begin
                if (topReturn)
                begin
                    next_r.st = ST_SAMPLE;
                end
            end
            default:
            begin
                next_r.st = ST_SAMPLE;
            end
        endcase
    end

    // state register; reset clears all pending, overrun and requests
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            r             <= '0;
            r.st          <= ST_SAMPLE;
            r.topSrcSel   <= TOP_SRC_RST;
            r.notMaskable <= TOP_NM_RST;
        end
        else
        begin
            r <= next_r;
        end
    end

    //--------------------------------------------------------------------------
    // outputs
    //--------------------------------------------------------------------------
    assign stdPendingLow   = r.pending[NUM_CAN-1:0];
    assign stdPendingHigh  = r.pending[NUM_STD-1:CH_I0];
    assign overrunFlags    = r.overrun;
    assign stdSharedVector = r.vector;
    assign topPending      = r.topPending;
    assign topSourceSelect = r.topSrcSel;
    assign topNotMaskable  = r.notMaskable;
    assign irqReq          = r.irqReq;
    assign topReq          = r.topReq;
    assign abortInstr      = r.abortInstr;
    assign finishFirst     = r.finishFirst;
    assign ackPulse        = r.ackPulse;
    assign ackIsTop        = r.winTop;
    assign ienClear        = r.ienClear;
    assign dmaBlock        = (r.st == ST_TOPSVC);
    assign entryCycles     = r.entryCycles;

    //--------------------------------------------------------------------------
    // assertions
    //--------------------------------------------------------------------------
    mask_gate_a: assert property (@(posedge clk) disable iff (!arst_n)
        $rose(r.st == ST_ARB) && !r.winTop |-> $past(globalIrqEnable)
            && ((($past(maskVec & r.pending) >> r.winIdx) & 10'h001) != 10'h000))
        else $error("masked or disabled channel chosen");

    never_seven_a: assert property (@(posedge clk) disable iff (!arst_n)
        stdFound |-> prio[winIdxC] != PRIO_NEVER)
        else $error("level seven channel chosen");

    pend_ack_clr_a: assert property (@(posedge clk) disable iff (!arst_n)
        (r.st == ST_ACK && !r.winTop && !stdEvt[r.winIdx] && !stdPendSet[r.winIdx])
        |=> !r.pending[$past(r.winIdx)])
        else $error("acknowledged pending not cleared");

    arb_five_a: assert property (@(posedge clk) disable iff (!arst_n)
        $rose(r.st == ST_ARB) |-> (r.st == ST_ARB)[*5] ##1 (r.st == ST_REQ))
        else $error("arbitration not five cycles");

    samp_period_a: assert property (@(posedge clk) disable iff (!arst_n)
        sampTick |=> (!sampTick)[*4] ##1 sampTick)
        else $error("sample spacing not five");

    ack_extra_a: assert property (@(posedge clk) disable iff (!arst_n)
        (r.st == ST_REQ && coreAck) |=> ackPulse && !irqReq && !topReq ##1 !ackPulse)
        else $error("acknowledge cycle wrong");

    ovr_set_a: assert property (@(posedge clk) disable iff (!arst_n)
        |(stdEvt & r.pending) |=> ((r.overrun & $past(stdEvt & r.pending))
                                    == $past(stdEvt & r.pending)))
        else $error("overrun not flagged");

    tnm_sticky_a: assert property (@(posedge clk) disable iff (!arst_n)
        r.notMaskable |=> r.notMaskable)
        else $error("not-maskable bit cleared");

    top_gate_a: assert property (@(posedge clk) disable iff (!arst_n)
        $rose(r.st == ST_ARB) && r.winTop |-> $past(r.topPending
            && (r.notMaskable || (topMaskableEnable && globalIrqEnable))))
        else $error("top request without enable");

    top_hold_a: assert property (@(posedge clk) disable iff (!arst_n)
        (r.st == ST_TOPSVC && !topReturn) |=> (r.st == ST_TOPSVC) && !irqReq && !topReq)
        else $error("top routine preempted");

    top_ien_a: assert property (@(posedge clk) disable iff (!arst_n)
        (r.st == ST_REQ && coreAck && r.winTop) |=> !ienClear)
        else $error("top entry touched global enable");

    abort_pick_a: assert property (@(posedge clk) disable iff (!arst_n)
        $rose(r.st == ST_REQ) |-> (abortInstr == !$past(coreWriteDone))
                                  && (finishFirst == $past(coreWriteDone)))
        else $error("abort choice wrong");

endmodule

// file: testbench/sti_core_model.sv
//------------------------------------------------------------------------------
// Purpose: core side of the irq unit, acknowledges requests
// Assumes: req levels change only at rising clk edges
// Notes:   ackDelay stretches the answer to model a slow core
//------------------------------------------------------------------------------
module sti_core_model (
    input  wire logic       clk,
    input  wire logic       irqReq,
    input  wire logic       topReq,
    input  wire logic [3:0] ackDelay,
    output logic            coreAck
);
    timeunit 1ns;
    timeprecision 100ps;

    // one-cycle acknowledge after the chosen delay, once req is seen high
    initial
    begin
        coreAck = 1'b0;
        forever
        begin
            @(posedge clk);
            if ((irqReq | topReq) === 1'b1)
            begin
                repeat (ackDelay) @(posedge clk);
                #2 coreAck = 1'b1;
                @(posedge clk);
                #2 coreAck = 1'b0;
            end
        end
    end
endmodule

// file: testbench/sti_irq_unit_tb.sv
//------------------------------------------------------------------------------
// Purpose: self-checking bench of the standard and top-level irq unit
// Assumes: inputs driven 2 ns after the rising edge
// Notes:   prints only mismatches and the verdict
//------------------------------------------------------------------------------
module sti_irq_unit_tb;
    timeunit 1ns;
    timeprecision 100ps;

    logic       clk, arst_n, serialSrc, chanI0EdgeSelect, stdMaskHigh, nmiPin, wdEndCount;
    logic       topSrcWr, topSrcData, topEdgeSelect, topMaskableEnable, topPendSet, topNmSet;
    logic       globalIrqEnable, coreAck, coreWriteDone, topReturn, stackInRegFile;
    logic       codeSegPushEnable, waitForIrq, topPending, topSourceSelect, topNotMaskable;
    logic       irqReq, topReq, abortInstr, finishFirst, ackPulse, ackIsTop, ienClear, dmaBlock;
    logic [7:0] canSrc, stdEdgeSelectLow, stdMaskLow, stdPriorityLow, stdPendingLow;
    logic [7:0] stdSharedVector;
    logic [9:0] stdPendSet, stdPendClr, overrunClr, overrunFlags;
    logic [2:0] vectorUpper, currentPriorityLevel;
    logic [1:0] stdPriorityHigh, stdPendingHigh;
    logic [4:0] entryCycles;
    logic [3:0] ackDelay;
    int         n_fail, total_checks, i;

    sti_irq_unit i_dut (.clk, .arst_n, .canSrc, .serialSrc, .stdEdgeSelectLow, .chanI0EdgeSelect,
        .stdMaskLow, .stdMaskHigh, .stdPriorityLow, .stdPriorityHigh, .vectorUpper, .stdPendSet,
        .stdPendClr, .overrunClr, .nmiPin, .wdEndCount, .topSrcWr, .topSrcData, .topEdgeSelect,
        .topMaskableEnable, .topPendSet, .topNmSet, .globalIrqEnable, .currentPriorityLevel,
        .coreAck, .coreWriteDone, .topReturn, .stackInRegFile, .codeSegPushEnable, .waitForIrq,
        .stdPendingLow, .stdPendingHigh, .overrunFlags, .stdSharedVector, .topPending,
        .topSourceSelect, .topNotMaskable, .irqReq, .topReq, .abortInstr, .finishFirst,
        .ackPulse, .ackIsTop, .ienClear, .dmaBlock, .entryCycles);

    sti_core_model i_core (.clk, .irqReq, .topReq, .ackDelay, .coreAck);

    // free-running 50 MHz clock
    initial
    begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end

    task automatic end_sim();
        if (n_fail == 0 && total_checks > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    task automatic chk(input string what, input logic [9:0] seen, input logic [9:0] exp);
        total_checks++;
        if (seen !== exp)
        begin
            n_fail++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic step(input int n);
        repeat (n) @(posedge clk);
        #2;
    endtask

    // bounded wait for irqReq (onAck low) or ackPulse, a spent bound ends the run
    task automatic waitHi(input bit onAck, input int lim);
        for (i = 0; i < lim && (onAck ? ackPulse : irqReq) !== 1'b1; i++)
            step(1);
        if ((onAck ? ackPulse : irqReq) !== 1'b1)
        begin
            n_fail++;
            end_sim();
        end
    endtask

    // main sequence
    initial
    begin
        {canSrc, serialSrc, stdMaskLow, stdMaskHigh, stdPriorityLow, stdPriorityHigh} = '0;
        {stdPendSet, stdPendClr, overrunClr, nmiPin, wdEndCount, topSrcWr, topSrcData} = '0;
        {topEdgeSelect, topMaskableEnable, topPendSet, topNmSet, topReturn, waitForIrq} = '0;
        {globalIrqEnable, coreWriteDone, stackInRegFile, codeSegPushEnable, ackDelay} = '0;
        {n_fail, total_checks} = '0;
        stdEdgeSelectLow = 8'hFF;
        chanI0EdgeSelect = 1'b1;
        vectorUpper = 3'h5;
        currentPriorityLevel = 3'h7;
        arst_n = 1'b0;
        step(10);
        arst_n = 1'b1;
        chk("topSrc", topSourceSelect, 1'h1);
        chk("rstReq", {irqReq, topReq, stdPendingLow}, 10'h0);
        chk("rstOvr", overrunFlags, 10'h0);
        globalIrqEnable = 1'b1;
        // each source marks its own channel, masked ones never request
        for (int k = 0; k < 9; k++)
        begin
            {serialSrc, canSrc} = 9'h1 << k;
            step(3);
            chk("pendOne", {stdPendingHigh, stdPendingLow}, 10'h1 << k);
            {serialSrc, canSrc} = 9'h0;
            stdPendClr = 10'h1 << k;
            step(1);
            stdPendClr = '0;
        end
        stdPendSet = 10'h3FF;
        step(1);
        stdPendSet = '0;
        canSrc = 8'h08;
        step(12);
        chk("allPend", {stdPendingHigh, stdPendingLow}, 10'h1FF);
        chk("overrun", overrunFlags, 10'h008);
        chk("maskedReq", irqReq, 1'h0);
        overrunClr = 10'h008;
        step(1);
        overrunClr = '0;
        chk("ovrClr", overrunFlags, 10'h000);
        stdPriorityLow = 8'hFF;
        stdPriorityHigh = 2'h1;
        step(2);
        chk("vecI0", stdSharedVector, 8'hB0);
        stdPriorityHigh = 2'h3;
        step(2);
        chk("vecTie", stdSharedVector, 8'hA0);
        stdPriorityLow = 8'hFB;
        step(2);
        chk("vecF0", stdSharedVector, 8'hA4);
        stdMaskLow = 8'h02;
        step(15);
        chk("lvl7", irqReq, 1'h0);
        // abort and finish-first requests with different entry modifiers
        for (int m = 0; m < 2; m++)
        begin
            ackDelay = 4'(m * 3);
            coreWriteDone = m[0];
            {stackInRegFile, codeSegPushEnable, waitForIrq} = m ? 3'h1 : 3'h6;
            stdMaskLow = m ? 8'h0E : 8'h06;
            waitHi(1'b0, 25);
            chk("abort", {abortInstr, finishFirst}, m ? 10'h1 : 10'h2);
            waitHi(1'b1, 20);
            chk("entry", {ienClear, ackIsTop, entryCycles}, m ? 10'h53 : 10'h56);
            step(1);
        end
        chk("ackClr", {stdPendingHigh, stdPendingLow}, 10'h1F3);
        {globalIrqEnable, stdMaskLow} = 9'h010;
        topMaskableEnable = 1'b1;
        nmiPin = 1'b1;
        step(3);
        chk("riseIgn", {topPending, irqReq}, 10'h0);
        nmiPin = 1'b0;
        step(15);
        chk("topMasked", {topPending, topReq}, 10'h2);
        topNmSet = 1'b1;
        step(1);
        topNmSet = 1'b0;
        chk("nmSet", topNotMaskable, 1'h1);
        waitHi(1'b1, 25);
        chk("topAck", {ackIsTop, ienClear}, 10'h2);
        step(1);
        chk("topSvc", {dmaBlock, topPending}, 10'h2);
        globalIrqEnable = 1'b1;
        topPendSet = 1'b1;
        step(1);
        topPendSet = 1'b0;
        step(15);
        chk("noPreempt", {irqReq, topReq}, 10'h0);
        topReturn = 1'b1;
        step(1);
        topReturn = 1'b0;
        waitHi(1'b1, 25);
        chk("topFirst", ackIsTop, 1'h1);
        step(1);
        topReturn = 1'b1;
        {topSrcWr, topSrcData} = 2'h2;
        step(1);
        {topReturn, topSrcWr} = 2'h0;
        wdEndCount = 1'b1;
        step(3);
        chk("wdSrc", {topSourceSelect, topPending}, 10'h1);
        end_sim();
    end
endmodule
